// ---- src/serial_cfg_consts.svh ----
// Purpose: offsets, field positions, reset values and framing counts of the serial configuration block
// Assumes: 13-bit register addresses, 8-bit registers
// Notes:   definitions only
`ifndef SERIAL_CFG_CONSTS_SVH
`define SERIAL_CFG_CONSTS_SVH

`define ADDR_W                 13
`define OFS_PORT_CONFIGURATION 13'h000
`define OFS_READBACK_SOURCE    13'h004
`define OFS_TAG_LOW            13'h005
`define OFS_TAG_HIGH           13'h006
`define OFS_NVM_STATUS         13'h0b00
`define OFS_NVM_ERROR          13'h0b01
`define OFS_NVM_CONTROL_ONE    13'h0b02
`define OFS_NVM_CONTROL_TWO    13'h0b03

`define RST_PORT_CONFIGURATION 8'h00
`define RST_READBACK_SOURCE    8'h00
`define RST_TAG                8'h00
`define RST_NVM_CONTROL        8'h00

`define MASK_PORT_CONFIGURATION 8'hef
`define MASK_READBACK_SOURCE    8'h01
`define MASK_NVM_CONTROL_ONE    8'h03
`define MASK_NVM_CONTROL_TWO    8'h01

`define BIT_SPLIT_DATA_PIN 7
`define BIT_LSB_FIRST      6
`define BIT_SOFT_RESET     5
`define BIT_READ_BUFFERED  0
`define BIT_NVM_WRITE_EN   0
`define BIT_SOFT_NVM_LOAD  1
`define BIT_SAVE_MAP       0

`define INSTR_LAST_BIT 4'hf
`define BYTE_LAST_BIT  3'h7
`define INSTR_READ_BIT 15

`endif

// ---- src/serial_cfg_pkg.sv ----
// Purpose: types shared by the serial configuration block
// Assumes: nothing beyond the constants header
// Notes:   pin group travels as one packed struct
package serial_cfg_pkg;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic sdio;
		logic io_update;
	} pins_t;

	typedef enum logic [1:0] {
		PH_INSTR = 2'b01,
		PH_DATA  = 2'b10
	} phase_t;

endpackage

// ---- src/pin_sync.sv ----
// Purpose: brings asynchronous pins into the clock domain
// Assumes: pins change slowly compared with the clock
// Notes:   a change is taken once the second and third stages agree
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 4
) (
	input  wire logic         clock,    // system clock
	input  wire logic         sys_rst,  // synchronous reset, active high
	input  wire logic [W-1:0] async_in, // raw pins
	output logic      [W-1:0] stable    // filtered pins
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clock)
			begin
				if (sys_rst)
				begin
					s1[i]     <= 1'b0;
					s2[i]     <= 1'b0;
					s3[i]     <= 1'b0;
					stable[i] <= 1'b0;
				end
				else
				begin
					s1[i] <= async_in[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i])
						stable[i] <= s3[i];
				end
			end
		end
	endgenerate
endmodule

// ---- src/serial_cfg_regs.sv ----
// Purpose: serial control port configuration and nonvolatile memory control registers
// Assumes: 3-wire or 4-wire serial port, pins slower than the 20 MHz clock
// Notes:   16-bit instruction (read flag, two length bits, 13-bit address), then streamed data bytes
`timescale 1ns/1ps
`include "serial_cfg_consts.svh"
module serial_cfg_regs (
	input  wire logic clock,                  // system clock, 20 MHz
	input  wire logic sys_rst,                // synchronous reset, active high
	input  wire logic sclk_pin,               // serial clock from host
	input  wire logic cs_n_pin,               // chip select, active low
	input  wire logic sdio_in,                // bidirectional data pin, input side
	output logic      sdio_out,               // bidirectional data pin, output side
	output logic      sdio_oe,                // bidirectional data pin, drive enable
	output logic      serial_data_out_pin,    // split read data pin
	output logic      serial_data_out_pin_oe, // split read data pin, drive enable
	input  wire logic io_update_pin,          // applies pending buffered values
	input  wire logic nvm_busy,               // nonvolatile transfer in progress
	input  wire logic nvm_data_error,         // nonvolatile data check failed
	output logic      nvm_write_enable,       // nonvolatile write allowed
	output logic      soft_nvm_load,          // request reload from nonvolatile memory
	output logic      save_map_to_nvm         // one-cycle request to store the map
);
	serial_cfg_pkg::pins_t  raw;
	serial_cfg_pkg::pins_t  pin;
	serial_cfg_pkg::phase_t phase;

	logic [7:0]            port_cfg;
	logic [7:0]            rb_sel;
	logic [7:0]            tag_lo;
	logic [7:0]            tag_hi;
	logic [7:0]            tag_lo_pend;
	logic [7:0]            tag_hi_pend;
	logic [7:0]            nvm_ctl1;
	logic [7:0]            nvm_ctl2;
	logic                  sclk_q;
	logic                  upd_q;
	logic [3:0]            bit_cnt;
	logic [15:0]           shift;
	logic [`ADDR_W-1:0]    addr;
	logic                  is_read;
	logic [7:0]            tx;
	logic                  skip;

	assign raw = '{sclk: sclk_pin, cs_n: cs_n_pin, sdio: sdio_in, io_update: io_update_pin};

	pin_sync #(.W(4)) u_sync (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.async_in (raw),
		.stable   (pin)
	);

	wire              cs_act      = ~pin.cs_n;
	wire              rise        = cs_act & pin.sclk & ~sclk_q;
	wire              fall        = cs_act & ~pin.sclk & sclk_q;
	wire              upd_edge    = pin.io_update & ~upd_q;
	wire              lsb         = port_cfg[`BIT_LSB_FIRST];
	wire              split       = port_cfg[`BIT_SPLIT_DATA_PIN];
	wire              soft_rst    = port_cfg[`BIT_SOFT_RESET];
	wire [15:0]       next_shift  = lsb ? {pin.sdio, shift[15:1]} : {shift[14:0], pin.sdio};
	wire [7:0]        byte_in     = lsb ? next_shift[15:8] : next_shift[7:0];
	wire              instr_done  = rise & (phase == serial_cfg_pkg::PH_INSTR) & (bit_cnt == `INSTR_LAST_BIT);
	wire              byte_done   = rise & (phase == serial_cfg_pkg::PH_DATA) & (bit_cnt[2:0] == `BYTE_LAST_BIT);
	wire [`ADDR_W-1:0] step_addr  = lsb ? addr + 13'h0001 : addr - 13'h0001;
	wire              wr_en       = byte_done & ~is_read;
	wire              load_tx     = (instr_done & next_shift[`INSTR_READ_BIT]) | (byte_done & is_read);
	wire [`ADDR_W-1:0] rd_addr    = instr_done ? next_shift[`ADDR_W-1:0] : step_addr;
	wire              buffered    = rb_sel[`BIT_READ_BUFFERED];
	wire [7:0]        tag_lo_view = buffered ? tag_lo_pend : tag_lo;
	wire [7:0]        tag_hi_view = buffered ? tag_hi_pend : tag_hi;
	wire              tx_bit      = lsb ? tx[0] : tx[7];
	wire              drive       = cs_act & (phase == serial_cfg_pkg::PH_DATA) & is_read;

	function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic logic [7:0] read_mux(input logic [`ADDR_W-1:0] a);
		read_mux = 8'h00;
		if (hit(a, `OFS_PORT_CONFIGURATION))
			read_mux = port_cfg;
		else if (hit(a, `OFS_READBACK_SOURCE))
			read_mux = rb_sel;
		else if (hit(a, `OFS_TAG_LOW))
			read_mux = tag_lo_view;
		else if (hit(a, `OFS_TAG_HIGH))
			read_mux = tag_hi_view;
		else if (hit(a, `OFS_NVM_STATUS))
			read_mux = {7'h00, nvm_busy};
		else if (hit(a, `OFS_NVM_ERROR))
			read_mux = {7'h00, nvm_data_error};
		else if (hit(a, `OFS_NVM_CONTROL_ONE))
			read_mux = nvm_ctl1;
		else if (hit(a, `OFS_NVM_CONTROL_TWO))
			read_mux = nvm_ctl2;
	endfunction

	// a process rather than a wire, so that the registers read inside the function also wake it up
	logic [7:0] read_value;

	always_comb
		read_value = read_mux(rd_addr);

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			sclk_q <= 1'b0;
			upd_q  <= 1'b0;
		end
		else
		begin
			sclk_q <= pin.sclk;
			upd_q  <= pin.io_update;
		end
	end

	// framing: instruction then bytes, restarted whenever select goes away
	always_ff @(posedge clock)
	begin
		if (sys_rst || !cs_act)
		begin
			phase   <= serial_cfg_pkg::PH_INSTR;
			bit_cnt <= 4'h0;
			shift   <= 16'h0000;
			is_read <= 1'b0;
			addr    <= '0;
		end
		else if (rise)
		begin
			shift   <= next_shift;
			bit_cnt <= bit_cnt + 4'h1;
			if (instr_done)
			begin
				phase   <= serial_cfg_pkg::PH_DATA;
				addr    <= next_shift[`ADDR_W-1:0];
				is_read <= next_shift[`INSTR_READ_BIT];
			end
			else if (byte_done)
				addr <= step_addr;
		end
	end

	// read shifter: the falling edge right after a load keeps the first bit
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			tx   <= 8'h00;
			skip <= 1'b0;
		end
		else if (load_tx)
		begin
			tx   <= read_value;
			skip <= 1'b1;
		end
		else if (fall && skip)
			skip <= 1'b0;
		else if (fall)
			tx <= lsb ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0};
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			sdio_out               <= 1'b0;
			sdio_oe                <= 1'b0;
			serial_data_out_pin    <= 1'b0;
			serial_data_out_pin_oe <= 1'b0;
		end
		else
		begin
			sdio_out               <= tx_bit;
			sdio_oe                <= drive & ~split;
			serial_data_out_pin    <= tx_bit;
			serial_data_out_pin_oe <= drive & split;
		end
	end

	// register file; soft reset acts one cycle after it is written
	always_ff @(posedge clock)
	begin
		if (sys_rst || soft_rst)
		begin
			port_cfg    <= `RST_PORT_CONFIGURATION;
			rb_sel      <= `RST_READBACK_SOURCE;
			tag_lo      <= `RST_TAG;
			tag_hi      <= `RST_TAG;
			tag_lo_pend <= `RST_TAG;
			tag_hi_pend <= `RST_TAG;
			nvm_ctl1    <= `RST_NVM_CONTROL;
			nvm_ctl2    <= `RST_NVM_CONTROL;
		end
		else
		begin
			if (wr_en && hit(addr, `OFS_PORT_CONFIGURATION))
				port_cfg <= byte_in & `MASK_PORT_CONFIGURATION;
			if (wr_en && hit(addr, `OFS_READBACK_SOURCE))
				rb_sel <= byte_in & `MASK_READBACK_SOURCE;
			if (wr_en && hit(addr, `OFS_TAG_LOW))
				tag_lo_pend <= byte_in;
			if (wr_en && hit(addr, `OFS_TAG_HIGH))
				tag_hi_pend <= byte_in;
			if (wr_en && hit(addr, `OFS_NVM_CONTROL_ONE))
				nvm_ctl1 <= byte_in & `MASK_NVM_CONTROL_ONE;
			if (wr_en && hit(addr, `OFS_NVM_CONTROL_TWO))
				nvm_ctl2 <= byte_in & `MASK_NVM_CONTROL_TWO;
			if (upd_edge)
			begin
				tag_lo <= tag_lo_pend;
				tag_hi <= tag_hi_pend;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst || soft_rst)
			save_map_to_nvm <= 1'b0;
		else
			save_map_to_nvm <= wr_en & hit(addr, `OFS_NVM_CONTROL_TWO) & byte_in[`BIT_SAVE_MAP]
				& nvm_ctl1[`BIT_NVM_WRITE_EN];
	end

	assign nvm_write_enable = nvm_ctl1[`BIT_NVM_WRITE_EN];
	assign soft_nvm_load    = nvm_ctl1[`BIT_SOFT_NVM_LOAD];

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	out_pin_float_a: assert property (!split |=> !serial_data_out_pin_oe)
		else $error("split read pin driven in bidirectional mode");
	split_sdio_quiet_a: assert property (split && $past(split) |-> !sdio_oe)
		else $error("bidirectional pin driven in split mode");
	addr_step_a: assert property (byte_done && !lsb |=> addr == $past(addr) - 13'h0001)
		else $error("address did not step in msb first mode");
	soft_reset_clear_a: assert property (soft_rst |=> port_cfg == `RST_PORT_CONFIGURATION
		&& tag_lo_pend == `RST_TAG && nvm_ctl1 == `RST_NVM_CONTROL)
		else $error("soft reset did not restore defaults");
	readback_pend_a: assert property (load_tx && buffered && hit(rd_addr, `OFS_TAG_LOW)
		|=> tx == $past(tag_lo_pend))
		else $error("buffered readback returned wrong value");
	tag_store_a: assert property (wr_en && hit(addr, `OFS_TAG_HIGH) && !soft_rst
		|=> tag_hi_pend == $past(byte_in))
		else $error("version tag write lost");
	nvm_status_ro_a: assert property (load_tx && hit(rd_addr, `OFS_NVM_STATUS)
		|=> tx == {7'h00, $past(nvm_busy)})
		else $error("status readback wrong");

	read_xfer_c: cover property (load_tx ##[1:200] byte_done);
	soft_reset_c: cover property (soft_rst);
	split_read_c: cover property (serial_data_out_pin_oe);
endmodule

// ---- tb/host_model.sv ----
// Purpose: host controller on the serial port, one transfer per call
// Assumes: sclk half period of 4 clocks, pins change on the falling clock edge
// Notes:   read bits are taken at the end of each high phase
`timescale 1ns/1ps
module host_model (
	input  wire logic clock,   // system clock
	output logic      sclk,    // serial clock
	output logic      cs_n,    // chip select, active low
	output logic      sdio,    // resolved bidirectional line
	input  wire logic dev_out, // device value on sdio
	input  wire logic dev_oe,  // device enable on sdio
	input  wire logic so,      // split read pin
	input  wire logic so_oe    // split read pin enable
);
	logic       hv = 1'b0;
	logic       r;
	logic [1:0] oe_seen;

	assign sdio = dev_oe ? dev_out : hv;

	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
	end

	task automatic bit_cycle(input logic b, input logic drv, input logic split);
		// a released line shows the inverse of its last value
		hv = drv ? b : ~hv;
		repeat (4) @(negedge clock);
		sclk = 1'b1;
		repeat (4) @(negedge clock);
		r = split ? (so_oe ? so : ~hv) : sdio;
		oe_seen = {dev_oe, so_oe};
		sclk = 1'b0;
	endtask

	task automatic xfer(input logic rd, input logic lsb, input logic split, input logic [12:0] a,
		input int n, input logic [15:0] wd, output logic [15:0] rdat, output logic [1:0] oes);
		logic [15:0] w;
		int          k;
		w = {rd, 2'b00, a};
		rdat = 16'h0000;
		cs_n = 1'b0;
		for (int i = 0; i < 16; i++)
			bit_cycle(lsb ? w[i] : w[15-i], 1'b1, split);
		for (int i = 0; i < 8 * n; i++)
		begin
			k = (i / 8) * 8 + (lsb ? i % 8 : 7 - i % 8);
			bit_cycle(wd[k], !rd, split);
			rdat[k] = r;
		end
		oes = oe_seen;
		cs_n = 1'b1;
		repeat (8) @(negedge clock);
	endtask
endmodule

// ---- tb/tb_serial_cfg_regs.sv ----
// Purpose: self-checking bench of the serial configuration registers
// Assumes: host model speaks the port, bench drives the rest at falling edges
// Notes:   multi-byte results hold stream byte 0 in bits 7:0
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t got %h expected %h", $time, a, b); end end
module tb_serial_cfg_regs;
	logic        clock, sys_rst, sclk, cs_n, sdio, sdio_out, sdio_oe, so, so_oe;
	logic        io_update, nvm_busy, nvm_err, nvm_we, nvm_load, save, lsb, split;
	logic [15:0] rdat;
	logic [1:0]  oes;
	int          fails, checks, saves;
	logic [12:0] addrs [8] = '{13'h000, 13'h004, 13'h005, 13'h006, 13'h0b00, 13'h0b01, 13'h0b02, 13'h0b03};

	serial_cfg_regs u_serial_cfg_regs (.clock(clock), .sys_rst(sys_rst), .sclk_pin(sclk), .cs_n_pin(cs_n),
		.sdio_in(sdio), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_data_out_pin(so),
		.serial_data_out_pin_oe(so_oe), .io_update_pin(io_update), .nvm_busy(nvm_busy),
		.nvm_data_error(nvm_err), .nvm_write_enable(nvm_we), .soft_nvm_load(nvm_load), .save_map_to_nvm(save));
	host_model u_host_model (.clock(clock), .sclk(sclk), .cs_n(cs_n), .sdio(sdio), .dev_out(sdio_out),
		.dev_oe(sdio_oe), .so(so), .so_oe(so_oe));

	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	always @(posedge clock)
		if (save === 1'b1)
			saves++;

	task automatic wr(input logic [12:0] a, input int n, input logic [15:0] d);
		u_host_model.xfer(1'b0, lsb, split, a, n, d, rdat, oes);
	endtask

	task automatic rd(input logic [12:0] a, input int n);
		u_host_model.xfer(1'b1, lsb, split, a, n, 16'h0000, rdat, oes);
	endtask

	task automatic give_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		repeat (40000) @(posedge clock);
		fails++;
		give_verdict;
	end

	initial
	begin
		{sys_rst, io_update, nvm_busy, nvm_err, lsb, split} = 6'b100000;
		{fails, checks, saves} = 0;
		repeat (20) @(negedge clock);
		sys_rst = 1'b0;
		repeat (8) @(negedge clock);
		foreach (addrs[i])
		begin
			rd(addrs[i], 1);
			`CHK(rdat[7:0], 8'h00)
		end
		$display("test 1 done");
		wr(13'h006, 2, 16'h3412);
		rd(13'h006, 2);
		`CHK(rdat, 16'h0000)
		rd(13'h000, 1);
		`CHK(rdat[7:0], 8'h00)
		wr(13'h004, 1, 16'h0001);
		rd(13'h006, 2);
		`CHK(rdat, 16'h3412)
		io_update = 1'b1;
		repeat (8) @(negedge clock);
		io_update = 1'b0;
		repeat (8) @(negedge clock);
		wr(13'h004, 1, 16'h0000);
		rd(13'h006, 2);
		`CHK(rdat, 16'h3412)
		$display("test 2 done");
		wr(13'h000, 1, 16'h0042);
		lsb = 1'b1;
		rd(13'h005, 2);
		`CHK(rdat, 16'h1234)
		rd(13'h000, 1);
		`CHK(rdat[7:0], 8'h42)
		wr(13'h000, 1, 16'h00c3);
		split = 1'b1;
		rd(13'h005, 1);
		`CHK(({oes, rdat[7:0]}), ({2'b01, 8'h34}))
		$display("test 3 done");
		wr(13'h000, 1, 16'h00e7);
		{lsb, split} = 2'b00;
		rd(13'h000, 1);
		`CHK(({oes, rdat[7:0]}), ({2'b10, 8'h00}))
		rd(13'h006, 2);
		`CHK(rdat, 16'h0000)
		$display("test 4 done");
		{nvm_busy, nvm_err} = 2'b11;
		wr(13'h0b01, 2, 16'hffff);
		rd(13'h0b01, 2);
		`CHK(rdat, 16'h0101)
		{nvm_busy, nvm_err} = 2'b00;
		rd(13'h0b01, 2);
		`CHK(rdat, 16'h0000)
		wr(13'h0b03, 1, 16'h0001);
		`CHK(saves, 0)
		wr(13'h0b02, 1, 16'h0003);
		`CHK(({nvm_we, nvm_load}), 2'b11)
		wr(13'h0b03, 1, 16'h0001);
		`CHK(saves, 1)
		wr(13'h100, 1, 16'h00ff);
		rd(13'h100, 1);
		`CHK(rdat[7:0], 8'h00)
		$display("test 5 done");
		give_verdict;
	end
endmodule
